// ===== iasq_cfg.svh
`ifndef IASQ_CFG_SVH
`define IASQ_CFG_SVH

// source count and widths
`define IASQ_N_SRC          16
`define IASQ_LVL_W          4
`define IASQ_CODE_W         12
`define IASQ_ADDR_W         32

// source classes, two bits per source
`define IASQ_CLS_PIN        2'h0
`define IASQ_CLS_PER_FAST   2'h1
`define IASQ_CLS_PER_SLOW   2'h2
`define IASQ_CLS_NMI        2'h3

// decision times in half peripheral cycles, as printed
`define IASQ_T_PIN_HALF     7
`define IASQ_T_FAST_HALF    3
`define IASQ_T_SLOW_HALF    6
`define IASQ_T_NMI_HALF     1
// least time rounds up to whole peripheral cycles
`define IASQ_CYC(h)         (((h) + 1) / 2)

// event code layout
`define IASQ_EVT_BASE       12'h200
`define IASQ_EVT2_BASE      12'h800
`define IASQ_EVT_STEP       12'h020

// status word field positions and reset value
`define IASQ_SR_MASK_LSB    0
`define IASQ_SR_HOLD_BIT    8
`define IASQ_SR_PRIV_BIT    9
`define IASQ_SR_BANK_BIT    10
`define IASQ_SR_RESET       32'h0000070f

// handler entry offset from the vector base
`define IASQ_ENTRY_OFS      32'h00000600

`endif

// ===== iasq_pkg.sv
package iasq_pkg;

   // selection result of one evaluation
   typedef struct packed
   {
      logic       valid;
      logic       nmi;
      logic [7:0] idx;
      logic [3:0] level;
   } iasq_pick_t;

   // acceptance sequencer states
   typedef enum logic [1:0]
   {
      IASQ_IDLE   = 2'b00,
      IASQ_SETTLE = 2'b01,
      IASQ_READY  = 2'b10
   } iasq_state_t;

endpackage

// ===== iasq_link_if.sv
`timescale 1ns/1ps
interface iasq_link_if;
   logic        irq_req;            // request forwarded to cpu
   logic [3:0]  irq_level;          // level of forwarded request
   logic        irq_nmi;            // forwarded request is non-maskable
   logic [11:0] event_code;         // first event code register
   logic [11:0] event_code_second;  // second event code register
   logic [3:0]  mask_level;         // cpu mask level field
   logic        hold_flag;          // cpu exception hold flag
   logic        take;               // cpu took the request, one cycle

   modport dev
   (
      output irq_req,
      output irq_level,
      output irq_nmi,
      output event_code,
      output event_code_second,
      input  mask_level,
      input  hold_flag,
      input  take
   );

   modport cpu
   (
      input  irq_req,
      input  irq_level,
      input  irq_nmi,
      input  event_code,
      input  event_code_second,
      output mask_level,
      output hold_flag,
      output take
   );
endinterface

// ===== iasq_device.sv
`timescale 1ns/1ps
`include "iasq_cfg.svh"
module iasq_device
#(
   parameter int                 N_SRC     = `IASQ_N_SRC,
   parameter logic [2*N_SRC-1:0] SRC_CLASS = '0,
   parameter logic [11:0]        EVT_BASE  = `IASQ_EVT_BASE,
   parameter logic [11:0]        EVT2_BASE = `IASQ_EVT2_BASE
)
(
   input  wire logic               core_clk_i,                // peripheral clk
   input  wire logic               rst_n_i,                   // async reset
   input  wire logic [N_SRC-1:0]   src_req_i,                 // async requests
   input  wire logic [4*N_SRC-1:0] priority_setting_regs_i,   // 4b per source
   iasq_link_if.dev                link,                      // cpu side
   output logic                    pending_indicator_pin_n_o, // low = pending
   output logic [11:0]             event_code_reg_o,          // event code
   output logic [11:0]             event_code_reg_second_o    // second code
);
   import iasq_pkg::*;

   localparam logic [2:0] LAT_PIN  = 3'(`IASQ_CYC(`IASQ_T_PIN_HALF));
   localparam logic [2:0] LAT_FAST = 3'(`IASQ_CYC(`IASQ_T_FAST_HALF));
   localparam logic [2:0] LAT_SLOW = 3'(`IASQ_CYC(`IASQ_T_SLOW_HALF));
   localparam logic [2:0] LAT_NMI  = 3'(`IASQ_CYC(`IASQ_T_NMI_HALF));

   // class of one source
   function automatic logic [1:0] src_class(input logic [7:0] idx);
      src_class = SRC_CLASS[2*idx +: 2];
   endfunction

   // decision latency of a source, in peripheral cycles
   function automatic logic [2:0] src_latency(input logic [7:0] idx);
      logic [1:0] cls;
      cls = src_class(idx);
      unique case (cls)
         `IASQ_CLS_PIN:      src_latency = LAT_PIN;
         `IASQ_CLS_PER_FAST: src_latency = LAT_FAST;
         `IASQ_CLS_PER_SLOW: src_latency = LAT_SLOW;
         `IASQ_CLS_NMI:      src_latency = LAT_NMI;
      endcase
   endfunction

   // pick the winner: nmi first, then level, ties to lowest index
   function automatic iasq_pick_t pick_winner
   (
      input logic [N_SRC-1:0]   req,
      input logic [4*N_SRC-1:0] prio
   );
      iasq_pick_t best;
      logic [3:0] lvl;
      logic       is_nmi;
      best = '0;
      for (int i = 0; i < N_SRC; i++)
      begin
         lvl    = prio[4*i +: 4];
         is_nmi = (src_class(8'(i)) == `IASQ_CLS_NMI);
         if (req[i] && !best.nmi && (is_nmi || lvl > best.level))
         begin
            best.valid = 1'b1;
            best.nmi   = is_nmi;
            best.idx   = 8'(i);
            best.level = lvl;
         end
      end
      pick_winner = best;
   endfunction

   // event code of a source
   function automatic logic [11:0] code_of
   (
      input logic [11:0] base,
      input logic [7:0]  idx
   );
      code_of = 12'(base + 12'(idx) * `IASQ_EVT_STEP);
   endfunction

   // two-flop synchronisers for the request lines
   logic [N_SRC-1:0] req_meta;
   logic [N_SRC-1:0] req_sync;

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         req_meta <= '0;
         req_sync <= '0;
      end
      else
      begin
         req_meta <= src_req_i;
         req_sync <= req_meta;
      end
   end

   // state of the selection
   iasq_pick_t  cur;
   iasq_state_t state;
   logic [2:0]  settle_cnt;
   logic        irq_req;
   logic [3:0]  irq_level;
   logic        irq_nmi;
   logic [7:0]  taken_idx;
   logic [11:0] evt;
   logic [11:0] evt2;

   // combinational decision, redone every clock
   wire iasq_pick_t pick       = pick_winner(req_sync,
                                             priority_setting_regs_i);
   wire logic       pick_moved = (pick != cur);
   wire logic [2:0] pick_lat   = src_latency(pick.idx);
   wire logic       above_mask = cur.nmi ||
                                 (cur.level > link.mask_level);
   wire logic       accept_w   = (state == IASQ_READY) && cur.valid &&
                                 above_mask;
   wire logic       new_source = accept_w && (!irq_req ||
                                              cur.idx != taken_idx);

   // next state of the settle sequencer
   iasq_state_t next_state;
   logic [2:0]  next_cnt;

   always_comb
   begin
      next_state = state;
      next_cnt   = settle_cnt;
      if (!pick.valid)
      begin
         next_state = IASQ_IDLE;
         next_cnt   = '0;
      end
      else if (pick_moved)
      begin
         // a new winner restarts the decision interval
         next_state = IASQ_SETTLE;
         next_cnt   = 3'(pick_lat - 3'h1);
      end
      else
      begin
         unique case (state)
            IASQ_IDLE:
            begin
               next_state = IASQ_SETTLE;
               next_cnt   = 3'(pick_lat - 3'h1);
            end
            IASQ_SETTLE:
            begin
               if (settle_cnt == 3'h0)
                  next_state = IASQ_READY;
               else
                  next_cnt = 3'(settle_cnt - 3'h1);
            end
            IASQ_READY:
               next_state = IASQ_READY;
            default:
               next_state = IASQ_IDLE;
         endcase
      end
   end

   // selection and sequencer registers
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cur        <= '0;
         state      <= IASQ_IDLE;
         settle_cnt <= '0;
      end
      else
      begin
         cur        <= pick;
         state      <= next_state;
         settle_cnt <= next_cnt;
      end
   end

   // request toward the cpu, dropped one edge after the selection is cleared or masked
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         irq_req                   <= 1'b0;
         irq_level                 <= '0;
         irq_nmi                   <= 1'b0;
         pending_indicator_pin_n_o <= 1'b1;
      end
      else
      begin
         irq_req                   <= accept_w;
         irq_level                 <= cur.level;
         irq_nmi                   <= cur.nmi;
         // hold flag deliberately not looked at here
         pending_indicator_pin_n_o <= !accept_w;
      end
   end

   // event codes load once per newly accepted source
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         evt       <= '0;
         evt2      <= '0;
         taken_idx <= '0;
      end
      else if (new_source)
      begin
         evt       <= code_of(EVT_BASE, cur.idx);
         evt2      <= code_of(EVT2_BASE, cur.idx);
         taken_idx <= cur.idx;
      end
   end

   // codes stay readable after the request drops
   assign link.irq_req           = irq_req;
   assign link.irq_level         = irq_level;
   assign link.irq_nmi           = irq_nmi;
   assign link.event_code        = evt;
   assign link.event_code_second = evt2;
   assign event_code_reg_o        = evt;
   assign event_code_reg_second_o = evt2;

endmodule

// ===== iasq_cpu.sv
`timescale 1ns/1ps
`include "iasq_cfg.svh"
module iasq_cpu
(
   input  wire logic        core_clk_i,          // peripheral clock
   input  wire logic        rst_n_i,             // async reset
   iasq_link_if.cpu         link,                // controller side
   input  wire logic        instr_done_i,        // instruction boundary pulse
   input  wire logic [31:0] pc_i,                // return address of boundary
   input  wire logic        status_wr_i,         // software writes status
   input  wire logic [31:0] status_wdata_i,      // status write data
   input  wire logic        vbr_wr_i,            // software writes vector base
   input  wire logic [31:0] vbr_wdata_i,         // vector base write data
   output logic [31:0]      cpu_status_word_o,   // status word
   output logic [31:0]      saved_status_copy_o, // saved status
   output logic [31:0]      saved_return_addr_o, // saved return address
   output logic             jump_o,              // handler jump, one cycle
   output logic [31:0]      jump_addr_o          // handler entry address
);
   import iasq_pkg::*;

   logic [31:0] sr;
   logic [31:0] vector_base;
   logic        take;

   // entry only at a boundary with the hold flag clear
   wire logic hold_w   = sr[`IASQ_SR_HOLD_BIT];
   wire logic enter_w  = instr_done_i && link.irq_req && !hold_w;
   // status with hold, privilege and bank set, mask untouched
   wire logic [31:0] entry_sr = sr | (32'h1 << `IASQ_SR_HOLD_BIT)
                                   | (32'h1 << `IASQ_SR_PRIV_BIT)
                                   | (32'h1 << `IASQ_SR_BANK_BIT);

   // status word and vector base
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sr          <= `IASQ_SR_RESET;
         vector_base <= '0;
      end
      else
      begin
         // entry wins over a software write in the same cycle
         if (enter_w)
            sr <= entry_sr;
         else if (status_wr_i)
            sr <= status_wdata_i;
         if (vbr_wr_i)
            vector_base <= vbr_wdata_i;
      end
   end

   // context save and jump
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         saved_status_copy_o <= '0;
         saved_return_addr_o <= '0;
         jump_o              <= 1'b0;
         jump_addr_o         <= '0;
         take                <= 1'b0;
      end
      else
      begin
         jump_o <= enter_w;
         take   <= enter_w;
         if (enter_w)
         begin
            saved_status_copy_o <= sr;
            saved_return_addr_o <= pc_i;
            jump_addr_o <= 32'(vector_base + `IASQ_ENTRY_OFS);
         end
      end
   end

   assign cpu_status_word_o = sr;
   assign link.mask_level   = sr[`IASQ_SR_MASK_LSB +: 4];
   assign link.hold_flag    = hold_w;
   assign link.take         = take;

endmodule

// ===== iasq_checker.sv
`timescale 1ns/1ps
module iasq_checker
(
   input  wire logic        core_clk_i,        // peripheral clock
   input  wire logic        rst_n_i,           // async reset
   input  wire logic        irq_req,           // forwarded request
   input  wire logic [3:0]  irq_level,         // forwarded level
   input  wire logic        irq_nmi,           // non-maskable flag
   input  wire logic [11:0] event_code,        // first code
   input  wire logic [11:0] event_code_second, // second code
   input  wire logic [3:0]  mask_level,        // cpu mask field
   input  wire logic        hold_flag,         // exception hold
   input  wire logic        take               // entry pulse
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // a mask change gets one edge of grace before the request must drop
   a_fwd_above_mask:
      assert property (irq_req && !irq_nmi && $stable(mask_level)
         |-> irq_level > mask_level) else $error("level not above mask");
   a_masked_drop:
      assert property (irq_req && !irq_nmi && irq_level <= mask_level
         |=> !irq_req) else $error("masked request still forwarded");
   a_level_nonzero:
      assert property (irq_req && !irq_nmi |-> irq_level != 4'h0)
         else $error("level zero forwarded");
   a_code_pair:
      assert property (irq_req |-> event_code_second == event_code + 12'h600)
         else $error("event codes disagree");
   a_code_step:
      assert property (irq_req |-> event_code[4:0] == 5'h00
         && event_code >= 12'h200) else $error("event code malformed");
   a_take_cause:
      assert property (take |-> $past(irq_req) && !$past(hold_flag))
         else $error("entry without open request");
   a_take_hold:
      assert property (take |-> hold_flag) else $error("hold not set");
   a_mask_kept:
      assert property (take |-> $stable(mask_level))
         else $error("entry changed mask");
   a_take_single:
      assert property (take |=> !take) else $error("entry pulse too long");
endmodule

// ===== test_interrupt_accept_sequencer.sv
`timescale 1ns/1ps
module test_interrupt_accept_sequencer;
   logic        core_clk_i;
   logic        rst_n_i;
   logic [15:0] src_req_i;
   logic [63:0] priority_setting_regs_i;
   logic        pending_indicator_pin_n_o;
   logic [11:0] event_code_reg_o;
   logic [11:0] event_code_reg_second_o;
   logic        instr_done_i;
   logic [31:0] pc_i;
   logic        status_wr_i;
   logic [31:0] status_wdata_i;
   logic        vbr_wr_i;
   logic [31:0] vbr_wdata_i;
   logic [31:0] cpu_status_word_o;
   logic [31:0] saved_status_copy_o;
   logic [31:0] saved_return_addr_o;
   logic        jump_o;
   logic [31:0] jump_addr_o;
   int          bad_count;
   int          total_checks;

   iasq_link_if link ();
   // src0 pin, src1 fast, src2 slow, src3 nmi, rest pin class
   iasq_device #(.SRC_CLASS(32'h000000e4)) iasq_device_inst
   (
      .core_clk_i, .rst_n_i, .src_req_i, .priority_setting_regs_i, .link,
      .pending_indicator_pin_n_o, .event_code_reg_o, .event_code_reg_second_o
   );
   iasq_cpu iasq_cpu_inst
   (
      .core_clk_i, .rst_n_i, .link, .instr_done_i, .pc_i, .status_wr_i,
      .status_wdata_i, .vbr_wr_i, .vbr_wdata_i, .cpu_status_word_o,
      .saved_status_copy_o, .saved_return_addr_o, .jump_o, .jump_addr_o
   );
   iasq_checker iasq_checker_inst
   (
      .core_clk_i, .rst_n_i, .irq_req(link.irq_req),
      .irq_level(link.irq_level), .irq_nmi(link.irq_nmi),
      .event_code(link.event_code),
      .event_code_second(link.event_code_second),
      .mask_level(link.mask_level), .hold_flag(link.hold_flag),
      .take(link.take)
   );

   // 250 MHz clock
   initial
   begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // bounded wait so a dead request path cannot hang the run
   task automatic wait_irq(input logic v, output int n);
      n = 0;
      do
      begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      while (link.irq_req !== v && n < 30);
   endtask

   task automatic wr_status(input logic [31:0] v);
      @(posedge core_clk_i);
      status_wr_i <= 1'b1;
      status_wdata_i <= v;
      @(posedge core_clk_i);
      status_wr_i <= 1'b0;
   endtask

   // one instruction boundary, then look at the edge that answers it;
   // jump_o stands for one cycle only, so look right after that edge
   task automatic boundary(input logic [31:0] pc);
      @(posedge core_clk_i);
      instr_done_i <= 1'b1;
      pc_i <= pc;
      @(posedge core_clk_i);
      instr_done_i <= 1'b0;
      #1;
   endtask

   task automatic t_reset();
      repeat (20) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      #1;
      chk(pending_indicator_pin_n_o, 1'b1);
      chk(link.irq_req, 1'b0);
      chk(event_code_reg_o, 12'h000);
      chk(cpu_status_word_o, 32'h0000070f);
      $display("test reset done");
   endtask

   task automatic t_latency();
      int n;
      int lat [4] = '{8, 6, 7, 5};
      wr_status(32'h00000600);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge core_clk_i);
         src_req_i[i] <= 1'b1;
         wait_irq(1'b1, n);
         chk(n, lat[i]);
         chk(pending_indicator_pin_n_o, 1'b0);
         chk(event_code_reg_o, 12'h200 + 12'h020 * i);
         chk(event_code_reg_second_o, 12'h800 + 12'h020 * i);
         @(posedge core_clk_i);
         src_req_i[i] <= 1'b0;
         wait_irq(1'b0, n);
         chk(pending_indicator_pin_n_o, 1'b1);
      end
      $display("test latency done");
   endtask

   task automatic t_priority();
      int n;
      @(posedge core_clk_i);
      priority_setting_regs_i[27:16] <= 12'h993;
      src_req_i[6:4] <= 3'b111;
      wait_irq(1'b1, n);
      chk(event_code_reg_o, 12'h2a0);
      chk(link.irq_level, 4'h9);
      wr_status(32'h00000609);
      wait_irq(1'b0, n);
      chk(pending_indicator_pin_n_o, 1'b1);
      repeat (12) @(posedge core_clk_i);
      #1;
      chk(link.irq_req, 1'b0);
      wr_status(32'h00000602);
      @(posedge core_clk_i);
      src_req_i[6:5] <= 2'b00;
      // generous bound over sync plus settle of the pin class
      repeat (20) @(posedge core_clk_i);
      #1;
      chk(link.irq_req, 1'b1);
      chk(event_code_reg_o, 12'h280);
      @(posedge core_clk_i);
      src_req_i[4] <= 1'b0;
      wait_irq(1'b0, n);
      $display("test priority done");
   endtask

   task automatic t_entry();
      int n;
      wr_status(32'h00000600);
      @(posedge core_clk_i);
      src_req_i[0] <= 1'b1;
      vbr_wr_i <= 1'b1;
      vbr_wdata_i <= 32'h80000000;
      @(posedge core_clk_i);
      vbr_wr_i <= 1'b0;
      wait_irq(1'b1, n);
      chk(jump_o, 1'b0);
      boundary(32'h00001234);
      chk(jump_o, 1'b1);
      chk(jump_addr_o, 32'h80000600);
      chk(saved_status_copy_o, 32'h00000600);
      chk(saved_return_addr_o, 32'h00001234);
      chk(cpu_status_word_o, 32'h00000700);
      boundary(32'h00002000);
      chk(jump_o, 1'b0);
      chk(pending_indicator_pin_n_o, 1'b0);
      wr_status(32'h00000605);
      wait_irq(1'b0, n);
      chk(pending_indicator_pin_n_o, 1'b1);
      @(posedge core_clk_i);
      src_req_i[5] <= 1'b1;
      wait_irq(1'b1, n);
      chk(event_code_reg_o, 12'h2a0);
      boundary(32'h00003000);
      chk(jump_o, 1'b1);
      chk(saved_status_copy_o, 32'h00000605);
      // handler clears the source and waits before reopening
      @(posedge core_clk_i);
      src_req_i <= '0;
      wait_irq(1'b0, n);
      chk(link.irq_req, 1'b0);
      wr_status(32'h00000600);
      boundary(32'h00004000);
      chk(jump_o, 1'b0);
      $display("test entry done");
   endtask

   // main sequence
   initial
   begin
      rst_n_i = 1'b0;
      src_req_i = '0;
      priority_setting_regs_i = {16{4'h5}};
      instr_done_i = 1'b0;
      pc_i = '0;
      status_wr_i = 1'b0;
      status_wdata_i = '0;
      vbr_wr_i = 1'b0;
      vbr_wdata_i = '0;
      bad_count = 0;
      total_checks = 0;
      t_reset();
      t_latency();
      t_priority();
      t_entry();
      summarize();
   end

   // watchdog, far beyond the roughly 160 cycles the tests need
   initial
   begin
      repeat (5000) @(posedge core_clk_i);
      bad_count++;
      summarize();
   end
endmodule
